// >>> core/fpcsb_consts.svh
`ifndef FPCSB_CONSTS_SVH
`define FPCSB_CONSTS_SVH

`define FPCSB_ADDR_W 4
`define FPCSB_OFF_CTX 4'h0
`define FPCSB_OFF_DBG 4'h4
`define FPCSB_OFF_EVT 4'h8

`define FPCSB_BIT_LAZY_ 0
`define FPCSB_BIT_USER_ 1
`define FPCSB_BIT_SEC_ 2
`define FPCSB_BIT_MODE_ 3
`define FPCSB_BIT_HF 4
`define FPCSB_BIT_MM 5
`define FPCSB_BIT_BF 6
`define FPCSB_BIT_SF 7
`define FPCSB_BIT_MON 8
`define FPCSB_BIT_SECMON 0
`define FPCSB_BIT_NSACC 1

`define FPCSB_CTX_WMASK 32'h0000017B
`define FPCSB_CTX_RST 32'h00000000
`define FPCSB_DBG_RST 32'h00000000

`endif

// >>> core/fpcsb_pkg.sv
package fpcsb_pkg;
   typedef logic [31:0] fpcsb_word_t;
   typedef enum logic [0:0] {
      FPCSB_HANDLER = 1'b0,
      FPCSB_THREAD = 1'b1
   } fpcsb_mode_e;
endpackage : fpcsb_pkg

// >>> core/fpcsb_top.sv
`timescale 1ns/1ps
`include "fpcsb_consts.svh"

module fpcsb_top
   import fpcsb_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [`FPCSB_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic frame_alloc_i,
   input wire logic alloc_thread_i,
   input wire logic alloc_unpriv_i,
   input wire logic alloc_dbgmon_ok_i,
   input wire logic alloc_busfault_ok_i,
   input wire logic alloc_memfault_ok_i,
   input wire logic alloc_hardfault_ok_i,
   input wire logic lazy_done_i,
   output logic lazy_save_active_o
);

   logic hardfault_pend_ok_reg;
   logic memfault_pend_ok_reg;
   logic busfault_pend_ok_reg;
   logic dbgmon_pend_ok_reg;
   logic user_reg;
   logic lazy_save_active_reg;
   logic [1:0] thread_bank_reg;
   logic secure_dbgmon_enable_reg;
   logic nsec_access_reg;
   logic [31:0] rdata_reg;

   // nsec_access selects the bank; the monitor bit is hidden only when secure_dbgmon_enable_reg is also set
   wire logic bank_sel = nsec_access_reg;
   wire logic mon_hidden = secure_dbgmon_enable_reg & nsec_access_reg;
   wire logic ctx_wr = wr_i & (addr_i == `FPCSB_OFF_CTX);
   wire logic dbg_wr = wr_i & (addr_i == `FPCSB_OFF_DBG);
   wire logic mon_wr_ok = ctx_wr & ~mon_hidden;

   wire fpcsb_word_t ctx_view = {23'h000000,
      dbgmon_pend_ok_reg & ~mon_hidden,
      1'b0,
      busfault_pend_ok_reg,
      memfault_pend_ok_reg,
      hardfault_pend_ok_reg,
      thread_bank_reg[bank_sel],
      1'b0,
      user_reg,
      lazy_save_active_reg};
   wire fpcsb_word_t dbg_view = {30'h00000000, nsec_access_reg, secure_dbgmon_enable_reg};
   wire fpcsb_word_t rd_mux = (addr_i == `FPCSB_OFF_CTX) ? ctx_view :
                              (addr_i == `FPCSB_OFF_DBG) ? dbg_view : 32'h00000000;

   // hardware capture on allocation wins over a same-cycle software write
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hardfault_pend_ok_reg <= 1'b0;
         memfault_pend_ok_reg <= 1'b0;
         busfault_pend_ok_reg <= 1'b0;
         dbgmon_pend_ok_reg <= 1'b0;
         user_reg <= 1'b0;
         thread_bank_reg <= 2'h0;
      end else if (frame_alloc_i) begin
         hardfault_pend_ok_reg <= alloc_hardfault_ok_i;
         memfault_pend_ok_reg <= alloc_memfault_ok_i;
         busfault_pend_ok_reg <= alloc_busfault_ok_i;
         dbgmon_pend_ok_reg <= alloc_dbgmon_ok_i;
         user_reg <= alloc_unpriv_i;
         thread_bank_reg[bank_sel] <= alloc_thread_i;
      end else if (ctx_wr) begin
         hardfault_pend_ok_reg <= wdata_i[`FPCSB_BIT_HF];
         memfault_pend_ok_reg <= wdata_i[`FPCSB_BIT_MM];
         busfault_pend_ok_reg <= wdata_i[`FPCSB_BIT_BF];
         if (mon_wr_ok) begin
            dbgmon_pend_ok_reg <= wdata_i[`FPCSB_BIT_MON];
         end
         user_reg <= wdata_i[`FPCSB_BIT_USER_];
         thread_bank_reg[bank_sel] <= wdata_i[`FPCSB_BIT_MODE_];
      end
   end

   // lazy flag: allocation sets it, completion clears it, software writes load it; allocation wins, then completion
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lazy_save_active_reg <= 1'b0;
      end else if (frame_alloc_i) begin
         lazy_save_active_reg <= 1'b1;
      end else if (lazy_done_i) begin
         lazy_save_active_reg <= 1'b0;
      end else if (ctx_wr) begin
         lazy_save_active_reg <= wdata_i[`FPCSB_BIT_LAZY_];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         secure_dbgmon_enable_reg <= 1'b0;
         nsec_access_reg <= 1'b0;
      end else if (dbg_wr) begin
         secure_dbgmon_enable_reg <= wdata_i[`FPCSB_BIT_SECMON];
         nsec_access_reg <= wdata_i[`FPCSB_BIT_NSACC];
      end
   end

   // mode bit deliberately drives nothing but the read path
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= rd_i ? rd_mux : 32'h00000000;
      end
   end

   assign rdata_o = rdata_reg;
   assign lazy_save_active_o = lazy_save_active_reg;

endmodule : fpcsb_top

// >>> verification/fpcsb_props.sv
`timescale 1ns/1ps
module fpcsb_props (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [3:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic frame_alloc_i,
   input wire logic alloc_thread_i,
   input wire logic alloc_unpriv_i,
   input wire logic alloc_hardfault_ok_i,
   input wire logic lazy_done_i,
   input wire logic lazy_save_active_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence al_rd;
      frame_alloc_i && !wr_i ##1 rd_i && addr_i == 4'h0 && !frame_alloc_i;
   endsequence
   chk_res_zero: assert property ((rdata_o & 32'hFFFFFE84) == 32'h0)
      else $error("rsv set");
   chk_lazy_set: assert property (frame_alloc_i |=> lazy_save_active_o)
      else $error("lazy set");
   chk_lazy_clr: assert property (lazy_done_i && !frame_alloc_i && !wr_i |=> !lazy_save_active_o)
      else $error("lazy clr");
   chk_lazy_hold: assert property (!frame_alloc_i && !lazy_done_i && !wr_i |=> $stable(lazy_save_active_o))
      else $error("lazy hold");
   chk_lazy_rd: assert property (rd_i && addr_i == 4'h0 |=> rdata_o[0] == $past(lazy_save_active_o))
      else $error("lazy rd");
   chk_hf_cap: assert property (al_rd |=> rdata_o[4] == $past(alloc_hardfault_ok_i, 2))
      else $error("hf cap");
   chk_user_cap: assert property (al_rd |=> rdata_o[1] == $past(alloc_unpriv_i, 2))
      else $error("user cap");
   chk_mode_cap: assert property (al_rd |=> rdata_o[3] == $past(alloc_thread_i, 2))
      else $error("mode cap");
endmodule : fpcsb_props
bind fpcsb_top fpcsb_props chk_u (.*);

// >>> verification/fp_context_status_bits_tb_top.sv
`timescale 1ns/1ps
module fp_context_status_bits_tb_top;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fa = 1'b0, ld = 1'b0, lz;
   logic th = 1'b0, up = 1'b0, dm = 1'b0, bf = 1'b0, mm = 1'b0, hf = 1'b0;
   logic [3:0] a = 4'h0;
   logic [31:0] wd = 32'h0, rdat;
   int err_count = 0, samples_checked = 0;
   logic [37:0] rows [5] = '{{6'h3F, 32'h17B}, {6'h00, 32'h001}, {6'h21, 32'h019},
      {6'h12, 32'h023}, {6'h0C, 32'h141}};
   always #4 clk = ~clk;
   fpcsb_top dut_u (.clk_i(clk), .sys_rst_i(rst), .addr_i(a), .wdata_i(wd), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdat), .frame_alloc_i(fa), .alloc_thread_i(th), .alloc_unpriv_i(up),
      .alloc_dbgmon_ok_i(dm), .alloc_busfault_ok_i(bf), .alloc_memfault_ok_i(mm),
      .alloc_hardfault_ok_i(hf), .lazy_done_i(ld), .lazy_save_active_o(lz));
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr_t(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk) {a, wd, wr} <= {ad, d, 1'b1};
      @(posedge clk) wr <= 1'b0;
   endtask : wr_t
   // leaves the allocation pulse up so the read follows it directly
   task al(input logic [5:0] v);
      @(posedge clk) {th, up, dm, bf, mm, hf, fa} <= {v, 1'b1};
   endtask : al
   task rc(input logic [3:0] ad, input logic [31:0] e);
      @(posedge clk) {a, rd, fa} <= {ad, 2'b10};
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdat, e);
   endtask : rc
   task close_out;
      if (err_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rc(4'h0, 32'h0);
      foreach (rows[i]) begin
         al(rows[i][37:32]);
         rc(4'h0, rows[i][31:0]);
      end
      chk({31'h0, lz}, 32'h1);
      wr_t(4'h0, 32'hFFFFFFFF);
      rc(4'h0, 32'h17B);
      @(posedge clk) ld <= 1'b1;
      @(posedge clk) ld <= 1'b0;
      rc(4'h0, 32'h17A);
      wr_t(4'h4, 32'h3);
      al(6'h08);
      rc(4'h0, 32'h001);
      wr_t(4'h0, 32'h0);
      rc(4'h0, 32'h0);
      wr_t(4'h4, 32'h2);
      rc(4'h0, 32'h100);
      rc(4'h8, 32'h0);
      close_out();
   end
   initial begin
      #20us;
      err_count++;
      close_out();
   end
endmodule : fp_context_status_bits_tb_top
